// >>> hbc_pkg.sv
// Package of constants and types for the bridge control and protection block
package hbc_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int OFF_TIME_US = 20;
  localparam int OFF_TIME_CYC = OFF_TIME_US * CLK_MHZ;
  localparam int DEAD_TIME_NS = 100;
  localparam int CLK_PERIOD_NS = 4;
  localparam int DEAD_TIME_CYC = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OFF_CNT_W = 13;
  localparam int DEAD_CNT_W = 6;
  // ----------------------------------------
  // Thermal derating
  // ----------------------------------------
  localparam int DERATE_W = 4;
  localparam logic [DERATE_W-1:0] DERATE_NONE = 4'h0;
  // ----------------------------------------
  // Interrupt status and mask layout
  // ----------------------------------------
  localparam int IRQ_W = 4;
  localparam int IRQ_UV = 0;
  localparam int IRQ_SC = 1;
  localparam int IRQ_OT = 2;
  localparam int IRQ_ILIM = 3;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 4'h4;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'h8;
  localparam int ST_SLEEP = 0;
  localparam int ST_UV = 1;
  localparam int ST_SC = 2;
  localparam int ST_OT = 3;
  localparam int ST_LIMIT = 4;
  localparam int ST_FAULT_N = 5;
  // ----------------------------------------
  // Leg drive and bridge states
  // ----------------------------------------
  typedef enum logic [1:0] {
    HBC_LEG_OFF = 2'b00,
    HBC_LEG_HIGH = 2'b01,
    HBC_LEG_LOW = 2'b10
  } hbc_leg_t;
  typedef enum logic [1:0] {
    HBC_BR_SLEEP = 2'b00,
    HBC_BR_HIZ = 2'b01,
    HBC_BR_LIMIT = 2'b10,
    HBC_BR_RUN = 2'b11
  } hbc_state_t;
endpackage

// >>> hbc_bridge.sv
// Control, protection and register logic of the two-leg bridge driver
module hbc_bridge (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic disable_active_high,
  input wire logic disable_active_low,
  input wire logic polarity_in_a,
  input wire logic polarity_in_b,
  input wire logic undervoltage,
  input wire logic short_circuit,
  input wire logic overtemp_threshold,
  input wire logic overtemp_clear,
  input wire logic [hbc_pkg::DERATE_W-1:0] derate_level,
  input wire logic [hbc_pkg::DERATE_W-1:0] current_level,
  output logic leg_a_high_on,
  output logic leg_a_low_on,
  output logic leg_b_high_on,
  output logic leg_b_low_on,
  output logic fault_flag_n_out,
  output logic fault_flag_n_oe,
  output logic [hbc_pkg::DERATE_W-1:0] current_limit_threshold,
  input wire logic [hbc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [hbc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [hbc_pkg::DATA_W-1:0] reg_rdata,
  output logic irq
);
  import hbc_pkg::*;

  // ----------------------------------------
  // Input history and fault latches
  // ----------------------------------------
  logic dah_q, dah_d, dal_q, dal_d;
  logic sc_q, sc_d, ot_q, ot_d, ot_wait_q, ot_wait_d;
  logic clear_edge;
  logic [OFF_CNT_W-1:0] off_cnt_q, off_cnt_d;
  logic over_limit, fault;
  hbc_state_t state;

  always_comb begin
    // Disable release edges clear the short-circuit latch and move an overtemp latch to wait for overtemp_clear
    clear_edge = (dah_q && !disable_active_high) || (!dal_q && disable_active_low);
    dah_d = disable_active_high;
    dal_d = disable_active_low;
    sc_d = sc_q;
    ot_d = ot_q;
    ot_wait_d = ot_wait_q;
    if (clear_edge) begin
      sc_d = 1'b0;
      if (ot_q) begin
        ot_d = 1'b0;
        ot_wait_d = 1'b1;
      end
    end
    if (ot_wait_q && overtemp_clear) begin
      ot_wait_d = 1'b0;
    end
    if (short_circuit) begin
      sc_d = 1'b1;
    end
    if (overtemp_threshold) begin
      ot_d = 1'b1;
      ot_wait_d = 1'b0;
    end
  end

  // Limit lowered in the hot zone
  assign current_limit_threshold = (derate_level > DERATE_NONE) ? ~derate_level : ~DERATE_NONE;
  assign over_limit = (current_level >= current_limit_threshold);
  // Undervoltage is a live level, so it recovers alone
  assign fault = undervoltage || sc_q || ot_q || ot_wait_q;

  always_comb begin
    off_cnt_d = off_cnt_q;
    if (off_cnt_q != '0) begin
      off_cnt_d = off_cnt_q - 1'b1;
    end else if (state == HBC_BR_RUN && over_limit) begin
      off_cnt_d = OFF_CNT_W'(OFF_TIME_CYC);
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dah_q <= 1'b0;
      dal_q <= 1'b1;
      sc_q <= 1'b0;
      ot_q <= 1'b0;
      ot_wait_q <= 1'b0;
      off_cnt_q <= '0;
    end else begin
      dah_q <= dah_d;
      dal_q <= dal_d;
      sc_q <= sc_d;
      ot_q <= ot_d;
      ot_wait_q <= ot_wait_d;
      off_cnt_q <= off_cnt_d;
    end
  end

  // ----------------------------------------
  // Bridge state decode
  // ----------------------------------------
  always_comb begin
    case ({enable, disable_active_high || !disable_active_low || fault, off_cnt_q != '0})
      3'b000, 3'b001, 3'b010, 3'b011: state = HBC_BR_SLEEP;
      3'b110, 3'b111: state = HBC_BR_HIZ;
      3'b101: state = HBC_BR_LIMIT;
      3'b100: state = HBC_BR_RUN;
      default: state = HBC_BR_SLEEP;
    endcase
  end

  function automatic hbc_leg_t leg_cmd(input hbc_state_t st, input logic pol);
    // Each input sets its own leg equal inputs brake
    if (st == HBC_BR_RUN) begin
      leg_cmd = pol ? HBC_LEG_HIGH : HBC_LEG_LOW;
    end else begin
      leg_cmd = HBC_LEG_OFF;
    end
  endfunction

  // ----------------------------------------
  // Dead time per leg
  // ----------------------------------------
  hbc_leg_t want [2];
  logic [1:0] hi_on, lo_on;
  assign want[0] = leg_cmd(state, polarity_in_a);
  assign want[1] = leg_cmd(state, polarity_in_b);

  for (genvar g = 0; g < 2; g++) begin : g_leg
    hbc_leg_t cur_q, cur_d;
    logic [DEAD_CNT_W-1:0] dt_q, dt_d;
    always_comb begin
      cur_d = cur_q;
      dt_d = dt_q;
      if (want[g] == HBC_LEG_OFF) begin
        cur_d = HBC_LEG_OFF;
        dt_d = DEAD_CNT_W'(DEAD_TIME_CYC);
      end else if (cur_q != want[g]) begin
        if (cur_q != HBC_LEG_OFF) begin
          cur_d = HBC_LEG_OFF;
          dt_d = DEAD_CNT_W'(DEAD_TIME_CYC);
        end else if (dt_q != '0) begin
          dt_d = dt_q - 1'b1;
        end else begin
          cur_d = want[g];
        end
      end
    end
    always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
        cur_q <= HBC_LEG_OFF;
        dt_q <= '0;
      end else begin
        cur_q <= cur_d;
        dt_q <= dt_d;
      end
    end
    assign hi_on[g] = (cur_q == HBC_LEG_HIGH);
    assign lo_on[g] = (cur_q == HBC_LEG_LOW);
  end

  assign leg_a_high_on = hi_on[0];
  assign leg_a_low_on = lo_on[0];
  assign leg_b_high_on = hi_on[1];
  assign leg_b_low_on = lo_on[1];

  // Flag pulled low on fault or disable, sleep leaves it high
  assign fault_flag_n_out = 1'b0;
  assign fault_flag_n_oe = !(enable && state == HBC_BR_HIZ);

  // ----------------------------------------
  // Interrupts and registers
  // ----------------------------------------
  logic [IRQ_W-1:0] ist_q, ist_d, imask_q, imask_d, ev;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  assign ev = {(state == HBC_BR_RUN) && over_limit, ot_q, sc_q, undervoltage};

  always_comb begin
    ist_d = ist_q;
    imask_d = imask_q;
    rdata_d = '0;
    if (reg_wr && reg_addr == REG_IRQ_STAT) begin
      ist_d = ist_q & ~reg_wdata[IRQ_W-1:0];
    end
    if (reg_wr && reg_addr == REG_IRQ_MASK) begin
      imask_d = reg_wdata[IRQ_W-1:0];
    end
    ist_d = ist_d | ev;
    if (reg_rd) begin
      case (reg_addr)
        REG_STATUS: begin
          rdata_d[ST_SLEEP] = (state == HBC_BR_SLEEP);
          rdata_d[ST_UV] = undervoltage;
          rdata_d[ST_SC] = sc_q;
          rdata_d[ST_OT] = ot_q || ot_wait_q;
          rdata_d[ST_LIMIT] = (state == HBC_BR_LIMIT);
          rdata_d[ST_FAULT_N] = fault_flag_n_oe;
        end
        REG_IRQ_STAT: rdata_d[IRQ_W-1:0] = ist_q;
        REG_IRQ_MASK: rdata_d[IRQ_W-1:0] = imask_q;
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ist_q <= '0;
      imask_q <= IRQ_MASK_RST;
      rdata_q <= '0;
    end else begin
      ist_q <= ist_d;
      imask_q <= imask_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign irq = |(ist_q & imask_q);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_no_shoot;
    @(posedge core_clk) disable iff (!reset_n) !(leg_a_high_on && leg_a_low_on) && !(leg_b_high_on && leg_b_low_on);
  endproperty
  a_no_shoot: assert property (p_no_shoot) else $error("Leg shoot-through");

  property p_sleep_off;
    @(posedge core_clk) disable iff (!reset_n) !enable |=>
      !leg_a_high_on && !leg_a_low_on && !leg_b_high_on && !leg_b_low_on;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("Legs on in sleep");

  property p_dis_off;
    @(posedge core_clk) disable iff (!reset_n) (disable_active_high || !disable_active_low) |=>
      !leg_a_high_on && !leg_b_high_on && !leg_a_low_on && !leg_b_low_on;
  endproperty
  a_dis_off: assert property (p_dis_off) else $error("Legs on while disabled");

  property p_fault_flag;
    @(posedge core_clk) disable iff (!reset_n) (enable && undervoltage) |-> !fault_flag_n_oe;
  endproperty
  a_fault_flag: assert property (p_fault_flag) else $error("Flag not low on undervoltage");

  property p_sc_latch;
    @(posedge core_clk) disable iff (!reset_n) short_circuit ##1 !clear_edge |=> sc_q;
  endproperty
  a_sc_latch: assert property (p_sc_latch) else $error("Short circuit not latched");

  property p_clear;
    @(posedge core_clk) disable iff (!reset_n) clear_edge && !short_circuit |=> !sc_q;
  endproperty
  a_clear: assert property (p_clear) else $error("Disable edge did not clear");

  property p_off_time;
    @(posedge core_clk) disable iff (!reset_n) $rose(off_cnt_q != '0) |-> (state != HBC_BR_RUN) [*8];
  endproperty
  a_off_time: assert property (p_off_time) else $error("Off-time cut short");

  // Cycles spent in forward drive, saturating
  localparam int FWD_SETTLE = DEAD_TIME_CYC + 3;
  logic [5:0] fwd_cnt_q, fwd_cnt_d;
  always_comb begin
    fwd_cnt_d = '0;
    if (state == HBC_BR_RUN && polarity_in_a && !polarity_in_b) begin
      fwd_cnt_d = (fwd_cnt_q == 6'h3F) ? fwd_cnt_q : fwd_cnt_q + 6'h01;
    end
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      fwd_cnt_q <= '0;
    end else begin
      fwd_cnt_q <= fwd_cnt_d;
    end
  end

  sequence s_run_fwd;
    state == HBC_BR_RUN && polarity_in_a && !polarity_in_b;
  endsequence
  sequence s_fwd_settled;
    fwd_cnt_q >= 6'(FWD_SETTLE);
  endsequence
  property p_forward;
    @(posedge core_clk) disable iff (!reset_n) s_run_fwd ##0 s_fwd_settled |-> leg_a_high_on && leg_b_low_on;
  endproperty
  a_forward: assert property (p_forward) else $error("Forward drive wrong");

  property p_ot_wait;
    @(posedge core_clk) disable iff (!reset_n) ot_wait_q && !overtemp_clear |=>
      (fault_flag_n_oe == !enable) || ot_wait_q;
  endproperty
  a_ot_wait: assert property (p_ot_wait) else $error("Overtemp restart too early");

  sequence s_limit_trip;
    state == HBC_BR_RUN && over_limit;
  endsequence
  property p_limit_trip;
    @(posedge core_clk) disable iff (!reset_n) s_limit_trip |=>
      off_cnt_q == OFF_CNT_W'(OFF_TIME_CYC) && state != HBC_BR_RUN;
  endproperty
  a_limit_trip: assert property (p_limit_trip) else $error("Off-time not started on limit");
endmodule // hbc_bridge

// >>> hbc_host.sv
// Host controller model driving the bridge control pins
module hbc_host (
  input wire logic core_clk,
  input wire logic [4:0] cmd,
  output logic enable,
  output logic disable_active_high,
  output logic disable_active_low,
  output logic polarity_in_a,
  output logic polarity_in_b
);
  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  // Enable starts low, so the bridge sleeps until commanded
  initial {enable, disable_active_high, disable_active_low, polarity_in_a, polarity_in_b} = 5'h00;
  // Run pattern and disable edges are both issued through cmd
  always @(posedge core_clk) begin
    {enable, disable_active_high, disable_active_low, polarity_in_a, polarity_in_b} <= cmd;
  end
endmodule // hbc_host

// >>> tb_top.sv
// Self-checking testbench of the bridge control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import hbc_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [4:0] cmd = 5'h00;
  logic enable, disable_active_high, disable_active_low, polarity_in_a, polarity_in_b;
  logic undervoltage = 1'b0, short_circuit = 1'b0, overtemp_threshold = 1'b0, overtemp_clear = 1'b1;
  logic [DERATE_W-1:0] derate_level = 4'h0, current_level = 4'h0, current_limit_threshold, thr_e = 4'hF, d;
  logic leg_a_high_on, leg_a_low_on, leg_b_high_on, leg_b_low_on, fault_flag_n_out, fault_flag_n_oe, irq;
  logic [ADDR_W-1:0] reg_addr = 4'h0;
  logic [DATA_W-1:0] reg_wdata = 32'h0, reg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0, rd_p = 1'b0, chk = 1'b0, irq_e = 1'b0;
  logic [31:0] exp_q[$];
  int mismatches = 0, n_tests = 0, cyc = 0;
  // ----------------------------------------
  // Clock, host and design
  // ----------------------------------------
  always #2 core_clk = ~core_clk;
  hbc_host u_host (.core_clk(core_clk), .cmd(cmd), .enable(enable), .disable_active_high(disable_active_high),
    .disable_active_low(disable_active_low), .polarity_in_a(polarity_in_a), .polarity_in_b(polarity_in_b));
  hbc_bridge dut (.core_clk(core_clk), .reset_n(reset_n), .enable(enable),
    .disable_active_high(disable_active_high), .disable_active_low(disable_active_low),
    .polarity_in_a(polarity_in_a), .polarity_in_b(polarity_in_b), .undervoltage(undervoltage),
    .short_circuit(short_circuit), .overtemp_threshold(overtemp_threshold), .overtemp_clear(overtemp_clear),
    .derate_level(derate_level), .current_level(current_level), .leg_a_high_on(leg_a_high_on),
    .leg_a_low_on(leg_a_low_on), .leg_b_high_on(leg_b_high_on), .leg_b_low_on(leg_b_low_on),
    .fault_flag_n_out(fault_flag_n_out), .fault_flag_n_oe(fault_flag_n_oe),
    .current_limit_threshold(current_limit_threshold), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic pins(input logic [4:0] c, input logic [4:0] e);
    cmd <= c;
    tick(40);
    exp_q.push_back({21'h0, 1'b0, irq_e, thr_e, e});
    chk <= 1'b1;
    tick(1);
    chk <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    tick(1);
    reg_rd <= 1'b0;
    tick(1);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    tick(1);
    reg_wr <= 1'b0;
    tick(1);
  endtask
  task automatic cmp(input logic [31:0] got);
    logic [31:0] e;
    e = exp_q.pop_front();
    n_tests++;
    if (got !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, e);
    end
  endtask
  task automatic end_of_test();
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ----------------------------------------
  // Monitor and timeout
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (rd_p) cmp(reg_rdata);
    if (chk) cmp({21'h0, fault_flag_n_out, irq, current_limit_threshold, leg_a_high_on, leg_a_low_on, leg_b_high_on,
      leg_b_low_on, fault_flag_n_oe});
    rd_p <= reg_rd;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      end_of_test();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h3245));
    tick(2);
    reset_n <= 1'b1;
    rd(REG_IRQ_MASK, {28'h0, IRQ_MASK_RST});
    pins(5'h00, 5'h01);
    rd(REG_STATUS, 32'h21);
    for (int i = 0; i < 4; i++) pins({3'b101, i[1:0]}, {i[1], ~i[1], i[0], ~i[0], 1'b1});
    pins(5'h1E, 5'h00);
    pins(5'h12, 5'h00);
    undervoltage <= 1'b1;
    pins(5'h16, 5'h00);
    undervoltage <= 1'b0;
    pins(5'h16, 5'h13);
    short_circuit <= 1'b1;
    pins(5'h16, 5'h00);
    short_circuit <= 1'b0;
    pins(5'h17, 5'h00);
    pins(5'h1E, 5'h00);
    pins(5'h16, 5'h13);
    overtemp_threshold <= 1'b1;
    overtemp_clear <= 1'b0;
    pins(5'h16, 5'h00);
    overtemp_threshold <= 1'b0;
    pins(5'h12, 5'h00);
    pins(5'h16, 5'h00);
    overtemp_clear <= 1'b1;
    pins(5'h16, 5'h13);
    d = 4'($urandom_range(1, 14));
    derate_level <= d;
    thr_e = ~d;
    current_level <= ~d;
    pins(5'h16, 5'h01);
    current_level <= 4'h0;
    tick(4850);
    pins(5'h16, 5'h01);
    tick(100);
    pins(5'h16, 5'h13);
    rd(REG_IRQ_STAT, 32'hF);
    wr(REG_IRQ_MASK, 32'h2);
    irq_e = 1'b1;
    pins(5'h16, 5'h13);
    wr(REG_IRQ_STAT, 32'h2);
    irq_e = 1'b0;
    pins(5'h16, 5'h13);
    rd(REG_IRQ_STAT, 32'hD);
    rd(REG_IRQ_MASK, 32'h2);
    wr(4'hC, 32'hFFFFFFFF);
    rd(4'hC, 32'h0);
    rd(REG_STATUS, 32'h20);
    end_of_test();
  end
endmodule // tb_top
